// ### design/rmi_pkg.sv
// constants for the receive mode command information word builder
`default_nettype none
package rmi_pkg;
   localparam int unsigned WORD_W = 16;
   localparam int unsigned ADDR_W = 15;
   // information word bit positions
   localparam int unsigned POS_INVALID = 14;
   localparam int unsigned POS_GAP_BC = 13;
   localparam int unsigned POS_WCNT = 12;
   localparam int unsigned POS_SYNC = 11;
   localparam int unsigned POS_MESSAGE_ERROR_SUMMARY_FLAG = 10;
   localparam int unsigned POS_BUSY = 9;
   localparam int unsigned POS_ILL = 8;
   localparam int unsigned POS_BUS = 5;
   localparam int unsigned MC_W = 5;
   // offsets from the data pointer
   localparam logic [14:0] OFS_INFO = 15'h0000;
   localparam logic [14:0] OFS_TTAG = 15'h0001;
   localparam logic [14:0] OFS_DATA = 15'h0002;
   // mode codes with a data word have bit 4 set (0x10 through 0x1F)
   localparam int unsigned POS_MC_DATA = 4;
   localparam logic [15:0] INFO_RST = 16'h0000;
   typedef enum logic [1:0] {RMI_IDLE, RMI_COLLECT, RMI_STORE} rmi_state_t;
endpackage : rmi_pkg
`default_nettype wire

// ### design/rmi_word_assy.sv
// combinational assembly of the information word from collected flags
`default_nettype none
module rmi_word_assy (
   input wire logic gap_or_broadcast_flag,
   input wire logic gap_error_flag,
   input wire logic word_count_error_flag,
   input wire logic sync_type_error_flag,
   input wire logic invalid_word_error_flag,
   input wire logic responded_busy_flag,
   input wire logic illegal_command_flag,
   input wire logic bus_select_indicator,
   input wire logic [4:0] mode_code_field,
   output logic [15:0] info_word
);
   always_comb begin
      info_word = rmi_pkg::INFO_RST;
      info_word[rmi_pkg::POS_INVALID] = invalid_word_error_flag;
      info_word[rmi_pkg::POS_GAP_BC] = gap_or_broadcast_flag;
      info_word[rmi_pkg::POS_WCNT] = word_count_error_flag;
      info_word[rmi_pkg::POS_SYNC] = sync_type_error_flag;
      // broadcast is no error, so the summary takes the gap error alone
      info_word[rmi_pkg::POS_MESSAGE_ERROR_SUMMARY_FLAG] = invalid_word_error_flag |
         gap_error_flag | word_count_error_flag |
         sync_type_error_flag;
      info_word[rmi_pkg::POS_BUSY] = responded_busy_flag;
      info_word[rmi_pkg::POS_ILL] = illegal_command_flag;
      info_word[rmi_pkg::POS_BUS] = bus_select_indicator;
      info_word[rmi_pkg::MC_W-1:0] = mode_code_field;
   end
endmodule : rmi_word_assy
`default_nettype wire

// ### design/rmi_info_word.sv
// receive mode command message information word builder and writer
`default_nettype none
// Contract
// - with select 0, bit 13 flags bus activity right after data or early gap.
// - in broadcast meaning, bit 13 flags a broadcast receive mode command.
// - bit 12 flags missing mode data word or an extra word.
// - bit 11 flags command/status sync on the mode data word.
// - bit 10 set whenever any error bit 11 to 14 is set.
// - bit 9 flags a busy response, global or per-command.
// - bit 8 flags a one in the matching illegalization entry.
// - bit 5 is 0 for bus A, 1 for bus B.
// - bits 4 to 0 carry the command's mode code.
// - bit 14 flags Manchester or parity error in a data word.
// - info at pointer, time tag at +1, mode data at +2.
// - information word written only after the message completes.
module rmi_info_word (
   input wire logic mclk,
   input wire logic rst,
   input wire logic cfg_bcast_sel,
   input wire logic msg_start,
   input wire logic [4:0] mode_code_field,
   input wire logic bus_select_indicator,
   input wire logic msg_broadcast,
   input wire logic [14:0] data_pointer,
   input wire logic gap_event,
   input wire logic word_count_event,
   input wire logic sync_event,
   input wire logic invalid_word_event,
   input wire logic global_busy,
   input wire logic per_command_busy_bit,
   input wire logic illegal_entry,
   input wire logic data_word_valid,
   input wire logic [15:0] data_word,
   input wire logic [15:0] time_tag,
   input wire logic msg_done,
   output logic ram_we,
   output logic [14:0] ram_addr,
   output logic [15:0] ram_wdata,
   output logic busy
);
   typedef struct packed {
      rmi_pkg::rmi_state_t st;
      logic gap;
      logic wcnt;
      logic sync;
      logic inval;
      logic rbusy;
      logic ill;
      logic bus;
      logic bcast;
      logic [4:0] mc;
      logic [14:0] ptr;
      logic [15:0] ttag;
      logic [15:0] dword;
      logic [1:0] step;
      logic we;
      logic [14:0] addr;
      logic [15:0] wdata;
      logic busy;
   } rmi_regs_t;

   rmi_regs_t s_r;
   rmi_regs_t s_nxt;
   logic [15:0] info_word;
   logic gb_flag;
   logic gap_err;

   // mode codes 0x10 and up carry one data word
   function automatic logic mc_has_data(input logic [4:0] mc);
      mc_has_data = mc[rmi_pkg::POS_MC_DATA];
   endfunction : mc_has_data

   // shared RAM address of one slot of the message record
   function automatic logic [14:0] slot_addr(input logic [14:0] base,
      input logic [14:0] ofs);
      // wraps at the top of the address space, as the RAM itself does
      slot_addr = base + ofs;
   endfunction : slot_addr

   // busy answer comes from the global bit or the per-command bit
   function automatic logic busy_answer(input logic glob, input logic cmd);
      busy_answer = glob | cmd;
   endfunction : busy_answer

   // meaning of bit 13 follows the select bit
   assign gb_flag = cfg_bcast_sel ? s_r.bcast : s_r.gap;
   // gap errors count in the summary only while bit 13 reports them
   assign gap_err = s_r.gap & ~cfg_bcast_sel;

   rmi_word_assy u_assy (
      .gap_or_broadcast_flag(gb_flag),
      .gap_error_flag(gap_err),
      .word_count_error_flag(s_r.wcnt),
      .sync_type_error_flag(s_r.sync),
      .invalid_word_error_flag(s_r.inval),
      .responded_busy_flag(s_r.rbusy),
      .illegal_command_flag(s_r.ill),
      .bus_select_indicator(s_r.bus),
      .mode_code_field(s_r.mc),
      .info_word(info_word)
   );

   always_comb begin
      s_nxt = s_r;
      s_nxt.we = 1'b0;
      case (s_r.st)
         rmi_pkg::RMI_IDLE: begin
            if (msg_start) begin
               s_nxt.st = rmi_pkg::RMI_COLLECT;
               s_nxt.gap = 1'b0;
               s_nxt.wcnt = 1'b0;
               s_nxt.sync = 1'b0;
               s_nxt.inval = 1'b0;
               s_nxt.rbusy = busy_answer(global_busy,
                  per_command_busy_bit);
               s_nxt.ill = illegal_entry;
               s_nxt.bus = bus_select_indicator;
               s_nxt.bcast = msg_broadcast;
               s_nxt.mc = mode_code_field;
               s_nxt.ptr = data_pointer;
               s_nxt.dword = 16'h0000;
            end
         end
         rmi_pkg::RMI_COLLECT: begin
            // flags are sticky for the whole message
            s_nxt.gap = s_r.gap | gap_event;
            s_nxt.wcnt = s_r.wcnt | word_count_event;
            s_nxt.sync = s_r.sync | sync_event;
            s_nxt.inval = s_r.inval | invalid_word_event;
            if (data_word_valid) begin
               s_nxt.dword = data_word;
            end
            if (msg_done) begin
               s_nxt.st = rmi_pkg::RMI_STORE;
               s_nxt.ttag = time_tag;
               s_nxt.step = 2'h0;
            end
         end
         rmi_pkg::RMI_STORE: begin
            // information word only once the message is over
            s_nxt.we = 1'b1;
            s_nxt.step = s_r.step + 2'h1;
            case (s_r.step)
               2'h0: begin
                  s_nxt.addr = slot_addr(s_r.ptr,
                     rmi_pkg::OFS_INFO);
                  s_nxt.wdata = info_word;
               end
               2'h1: begin
                  s_nxt.addr = slot_addr(s_r.ptr, rmi_pkg::OFS_TTAG);
                  s_nxt.wdata = s_r.ttag;
                  if (!mc_has_data(s_r.mc)) begin
                     s_nxt.st = rmi_pkg::RMI_IDLE;
                  end
               end
               default: begin
                  s_nxt.addr = slot_addr(s_r.ptr, rmi_pkg::OFS_DATA);
                  s_nxt.wdata = s_r.dword;
                  s_nxt.st = rmi_pkg::RMI_IDLE;
               end
            endcase
         end
         default: begin
            s_nxt.st = rmi_pkg::RMI_IDLE;
         end
      endcase
      // busy drops together with the last slot write
      s_nxt.busy = s_nxt.st != rmi_pkg::RMI_IDLE;
   end

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         s_r <= '0;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign busy = s_r.busy;
   assign ram_we = s_r.we;
   assign ram_addr = s_r.addr;
   assign ram_wdata = s_r.wdata;
endmodule : rmi_info_word
`default_nettype wire

// ### tb/rmi_monitor.sv
// concurrent checks on the information word writer ports
`default_nettype none
module rmi_monitor (
   input wire logic mclk,
   input wire logic rst,
   input wire logic msg_done,
   input wire logic [4:0] mode_code_field,
   input wire logic bus_select_indicator,
   input wire logic [14:0] data_pointer,
   input wire logic ram_we,
   input wire logic [14:0] ram_addr,
   input wire logic [15:0] ram_wdata,
   input wire logic busy
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking @(posedge mclk); endclocking
   default disable iff (rst);
   logic fin;
   assign fin = msg_done && busy;
   AST_INFO_SLOT: assert property (fin |-> ##1 !ram_we ##1
      ram_we && ram_addr == data_pointer) else $error("info slot");
   AST_TTAG_SLOT: assert property (fin |-> ##3 ram_we &&
      ram_addr == data_pointer + 15'h0001) else $error("tag slot");
   AST_DATA_SLOT: assert property (fin && mode_code_field[4] |-> ##4
      ram_we && ram_addr == data_pointer + 15'h0002) else $error("data slot");
   AST_NO_DATA: assert property (fin && !mode_code_field[4] |-> ##4
      !ram_we) else $error("extra write");
   AST_WE_CAUSE: assert property (ram_we |-> $past(msg_done, 2) ||
      $past(ram_we)) else $error("early write");
   AST_UNUSED_ZERO: assert property (fin |-> ##2 !ram_wdata[15] &&
      ram_wdata[7:6] == 2'h0) else $error("unused bits");
   AST_ID_FIELDS: assert property (fin |-> ##2
      ram_wdata[5:0] == {bus_select_indicator, mode_code_field})
      else $error("bus or mode code");
   AST_SUMMARY: assert property (fin |-> ##2 ram_wdata[10] ||
      {ram_wdata[14], ram_wdata[12:11]} == 3'h0) else $error("summary");
endmodule : rmi_monitor
`default_nettype wire

// ### tb/rmi_bc_model.sv
// bus-side message source: command, events and completion pulses
`default_nettype none
module rmi_bc_model (
   input wire logic mclk,
   output logic msg_start,
   output logic gap_event,
   output logic word_count_event,
   output logic sync_event,
   output logic invalid_word_event,
   output logic data_word_valid,
   output logic msg_done
);
   timeunit 1ns;
   timeprecision 1ns;
   initial {msg_start, gap_event, word_count_event, sync_event,
      invalid_word_event, data_word_valid, msg_done} = 7'h0;
   task automatic send(input logic [31:0] r);
      @(negedge mclk);
      msg_start = 1'h1;
      @(negedge mclk);
      msg_start = r[11]; // restart while busy, must be refused
      gap_event = r[6] & ~r[0];
      word_count_event = r[7];
      sync_event = r[8];
      invalid_word_event = r[9];
      data_word_valid = r[10];
      @(negedge mclk);
      {msg_start, gap_event, word_count_event, data_word_valid} = 4'h0;
      msg_done = 1'h1;
      @(negedge mclk);
      msg_done = 1'h0;
      {sync_event, invalid_word_event} = 2'h3; // stray while storing
      @(negedge mclk);
      {sync_event, invalid_word_event} = 2'h0;
   endtask : send
endmodule : rmi_bc_model
`default_nettype wire

// ### tb/rmi_info_word_tb.sv
// self-checking bench for the information word writer
`default_nettype none
module rmi_info_word_tb;
   timeunit 1ns;
   timeprecision 1ns;
   logic mclk = 1'h0, rst = 1'h1, cfg_bcast_sel, bus_select_indicator;
   logic msg_broadcast, global_busy, per_command_busy_bit, illegal_entry;
   logic msg_start, gap_event, word_count_event, sync_event, msg_done;
   logic invalid_word_event, data_word_valid, ram_we, busy;
   logic [4:0] mode_code_field;
   logic [14:0] data_pointer, ram_addr, p;
   logic [15:0] data_word, time_tag, ram_wdata, info;
   logic [31:0] r, d, seed = 32'h25;
   logic [30:0] got[$];
   int error_cnt = 0, samples_checked = 0, cyc = 0;
   always #25 mclk = ~mclk;
   rmi_info_word rmi_info_word_inst (.mclk, .rst, .cfg_bcast_sel, .msg_start,
      .mode_code_field, .bus_select_indicator, .msg_broadcast, .data_pointer,
      .gap_event, .word_count_event, .sync_event, .invalid_word_event,
      .global_busy, .per_command_busy_bit, .illegal_entry, .data_word_valid,
      .data_word, .time_tag, .msg_done, .ram_we, .ram_addr, .ram_wdata, .busy);
   rmi_bc_model rmi_bc_model_inst (.mclk, .msg_start, .gap_event,
      .word_count_event, .sync_event, .invalid_word_event, .data_word_valid,
      .msg_done);
   task automatic check(input string nm, input logic [31:0] s, e);
      samples_checked++;
      if (s !== e) error_cnt++;
      if (s !== e) $display("[FAIL] %s expected %h seen %h", nm, e, s);
   endtask : check
   function automatic logic [31:0] xorshift(input logic [31:0] v);
      logic [31:0] t;
      t = v ^ (v << 13);
      t = t ^ (t >> 17);
      xorshift = t ^ (t << 5);
   endfunction : xorshift
   task automatic print_verdict(input int extra);
      error_cnt += extra;
      $display("checks %0d errors %0d", samples_checked, error_cnt);
      if (error_cnt == 0 && samples_checked > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask : print_verdict
   always @(negedge mclk) begin
      if (ram_we === 1'h1) got.push_back({ram_addr, ram_wdata});
      cyc++;
      if (cyc == 3000) print_verdict(1);
   end
   initial begin
      {cfg_bcast_sel, bus_select_indicator, msg_broadcast, global_busy} = 4'h0;
      {per_command_busy_bit, illegal_entry, mode_code_field} = 7'h0;
      {data_pointer, data_word, time_tag} = 47'h0;
      repeat (8) @(negedge mclk);
      check("reset", {ram_we, busy, ram_wdata}, 18'h0);
      rst = 1'h0;
      for (int i = 0; i < 96; i++) begin
         repeat (2) begin
            seed = xorshift(seed);
            d = r;
            r = seed;
         end
         {illegal_entry, per_command_busy_bit, global_busy} = r[5:3];
         {bus_select_indicator, msg_broadcast, cfg_bcast_sel} = r[2:0];
         {mode_code_field, data_pointer} = {i[4:0], r[26:12]};
         {data_word, time_tag} = d;
         rmi_bc_model_inst.send(r);
         for (int k = 0; k < 9 && busy !== 1'h0; k++) @(negedge mclk);
         @(negedge mclk);
         info = {1'h0, r[9], r[0] ? r[1] : r[6], r[7], r[8],
            r[9] | r[8] | r[7] | (r[6] & ~r[0]), r[4] | r[3], r[5], 2'h0,
            r[2], i[4:0]};
         p = r[26:12];
         check("info", got[0], {p, info});
         check("flags", got[0][14:8], info[14:8]);
         check("ident", got[0][5:0], info[5:0]);
         p = p + 15'h0001;
         check("time tag", got[1], {p, d[15:0]});
         p = p + 15'h0001;
         if (i[4]) check("data", got[2], {p, r[10] ? d[31:16] : 16'h0});
         check("writes", got.size(), 2 + i[4]);
         got.delete();
      end
      print_verdict(0);
   end
endmodule : rmi_info_word_tb
bind rmi_info_word rmi_monitor rmi_monitor_inst (.mclk, .rst, .msg_done,
   .mode_code_field, .bus_select_indicator, .data_pointer, .ram_we,
   .ram_addr, .ram_wdata, .busy);
`default_nettype wire
